// file: common/segx_defines.vh
// constants of the segment address extension block
// Function
// - far jump/call/return reload the code segment
// - relocate bit swaps page regs with port regs
// - save-segment bit resets clear, compatibility mode
// - compat mode: interrupt segment fetches, short frame
// - save mode: push code segment, load from interrupt
// - save mode: interrupt exit restores code segment
// - data paging identical inside and outside ISRs
// - transfer select picks interrupt or transfer segment
// - first 256 program bytes hold the vectors
// - vectors high byte first at 0, 2, 4
// - program address is segment over virtual address
// - top two bits pick page register, 14-bit offset
// - selected interrupt or transfer segment supplies A21-16 over DMA address
`ifndef SEGX_DEFINES_VH
`define SEGX_DEFINES_VH

// widths
`define SEGX_SEG_W        6
`define SEGX_PAGE_W       8
`define SEGX_VADDR_W      16
`define SEGX_PADDR_W      22
`define SEGX_OFS_W        14
`define SEGX_ADDR_W       6

// register byte offsets on the bus
`define SEGX_OFS_PAGE0    6'h00
`define SEGX_OFS_PAGE1    6'h04
`define SEGX_OFS_PAGE2    6'h08
`define SEGX_OFS_PAGE3    6'h0C
`define SEGX_OFS_CODESEG  6'h10
`define SEGX_OFS_IRQSEG   6'h14
`define SEGX_OFS_XFERSEG  6'h18
`define SEGX_OFS_EXTMODE  6'h1C
`define SEGX_OFS_XFERPFX  6'h20
`define SEGX_OFS_STATUS   6'h24
`define SEGX_OFS_GRPE0    6'h28
`define SEGX_OFS_GRPE3    6'h34

// field positions
`define SEGX_BIT_RELOC    5
`define SEGX_BIT_SAVECS   6
`define SEGX_BIT_XSEL     0
`define SEGX_BIT_INSVC    0
`define SEGX_BIT_NEST_LO  4

// reset values
`define SEGX_RST_SEG      6'h00
`define SEGX_RST_PAGE     8'h00
`define SEGX_RST_MODE     8'h00

// vector layout in low program memory
`define SEGX_VK_RESET     2'h0
`define SEGX_VK_DIVZ      2'h1
`define SEGX_VK_TOP       2'h2
`define SEGX_VK_TABLE     2'h3
`define SEGX_VEC_RESET    16'h0000
`define SEGX_VEC_DIVZ     16'h0002
`define SEGX_VEC_TOP      16'h0004
`define SEGX_NEST_W       4
`define SEGX_NEST_MAX     4'hF

`endif

// file: verif/segx_mmu_properties.sv
// assertions on the ports of the segment address extension unit
`timescale 1ns/1ps
module segx_mmu_properties (
    input wire        CLK_IN,
    input wire        SYS_RST_IN,
    input wire        AVS_READ_IN,
    input wire        AVS_WRITE_IN,
    input wire        AVS_WAITREQUEST_OUT,
    input wire [3:0]  PORT_WE_OUT,
    input wire        PORTS_IN_PAGE21_OUT,
    input wire [15:0] FETCH_VADDR_IN,
    input wire [21:0] PROG_ADDR_OUT,
    input wire [15:0] DATA_VADDR_IN,
    input wire [21:0] DATA_ADDR_OUT,
    input wire [15:0] DMA_VADDR_IN,
    input wire [21:0] DMA_ADDR_OUT,
    input wire [1:0]  VEC_KIND_IN,
    input wire [21:0] VEC_HI_ADDR_OUT,
    input wire [21:0] VEC_LO_ADDR_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    prog_offset_a: assert property (
        !$past(SYS_RST_IN) |-> PROG_ADDR_OUT[15:0] == $past(FETCH_VADDR_IN)) else $error("fetch offset");
    data_offset_a: assert property (
        !$past(SYS_RST_IN) |-> DATA_ADDR_OUT[13:0] == $past(DATA_VADDR_IN[13:0])) else $error("page offset");
    dma_offset_a: assert property (
        !$past(SYS_RST_IN) |-> DMA_ADDR_OUT[15:0] == $past(DMA_VADDR_IN)) else $error("dma offset");
    one_wait_a: assert property (
        (AVS_READ_IN || AVS_WRITE_IN) && !$past(AVS_READ_IN || AVS_WRITE_IN)
        |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT) else $error("wait state");
    port_pulse_a: assert property (
        |PORT_WE_OUT |-> $past(AVS_WRITE_IN && !AVS_WAITREQUEST_OUT) ##1 PORT_WE_OUT == 4'h0)
        else $error("port strobe");
    reloc_hold_a: assert property (
        !$past(AVS_WRITE_IN) && !$past(SYS_RST_IN) |-> $stable(PORTS_IN_PAGE21_OUT))
        else $error("relocate moved");
    vec_reset_a: assert property (
        VEC_KIND_IN == 2'h0 |=> VEC_HI_ADDR_OUT == 22'h000000 && VEC_LO_ADDR_OUT == 22'h000001)
        else $error("reset vector");
    vec_trap_a: assert property (
        VEC_KIND_IN == 2'h1 |=> VEC_HI_ADDR_OUT[15:0] == 16'h0002 && VEC_LO_ADDR_OUT[15:0] == 16'h0003)
        else $error("trap vector");
    vec_top_a: assert property (
        VEC_KIND_IN == 2'h2 |=> VEC_HI_ADDR_OUT[15:0] == 16'h0004 && VEC_LO_ADDR_OUT[15:0] == 16'h0005)
        else $error("top vector");
    // main scenarios reached
    cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
    cover property (|PORT_WE_OUT);
    cover property (PORTS_IN_PAGE21_OUT);
endmodule // segx_mmu_properties
bind segx_mmu segx_mmu_properties segx_mmu_properties_i (.CLK_IN, .SYS_RST_IN, .AVS_READ_IN,
    .AVS_WRITE_IN, .AVS_WAITREQUEST_OUT, .PORT_WE_OUT, .PORTS_IN_PAGE21_OUT, .FETCH_VADDR_IN,
    .PROG_ADDR_OUT, .DATA_VADDR_IN, .DATA_ADDR_OUT, .DMA_VADDR_IN, .DMA_ADDR_OUT, .VEC_KIND_IN,
    .VEC_HI_ADDR_OUT, .VEC_LO_ADDR_OUT);

// file: verif/segx_port_model.sv
// port 0-3 data registers standing outside the unit
`timescale 1ns/1ps
module segx_port_model (
    input  wire        CLK_IN,
    input  wire        SYS_RST_IN,
    input  wire [3:0]  PORT_WE_IN,
    input  wire [7:0]  PORT_WDATA_IN,
    output reg  [31:0] PORT_RDATA_OUT
);
    integer n;
    always @(posedge CLK_IN) begin
        for (n = 0; n < 4; n = n + 1)
            if (SYS_RST_IN)
                PORT_RDATA_OUT[n*8 +: 8] <= 8'hFF; // ports reset high
            else if (PORT_WE_IN[n])
                PORT_RDATA_OUT[n*8 +: 8] <= PORT_WDATA_IN;
    end
endmodule // segx_port_model

// file: verif/test_segx_mmu.sv
// self-checking bench of the segment address extension unit
`timescale 1ns/1ps
module test_segx_mmu;
    reg          CLK_IN = 1'h0;
    reg          SYS_RST_IN = 1'h1;
    reg  [5:0]   adr = 6'h00;
    reg          rd = 1'h0;
    reg          wr = 1'h0;
    reg  [31:0]  wd = 32'h0;
    reg  [3:0]   be = 4'hF;
    reg          fl = 1'h0, fr = 1'h0, ie = 1'h0, ix = 1'h0, aval = 1'h0, av1 = 1'h0;
    reg  [5:0]   fs = 6'h00, ps = 6'h00, cs = 6'h00, is, xs, old;
    reg  [15:0]  fv = 16'h0, dv = 16'h0, mv = 16'h0;
    reg  [1:0]   vk = 2'h0;
    reg  [7:0]   vp = 8'h00;
    reg  [7:0]   pg [0:3];
    reg          sv = 1'h0, xsel = 1'h0, insv = 1'h0, reloc = 1'h0;
    reg  [31:0]  rq [$];
    reg  [118:0] aq [$];
    wire [31:0]  rdat, prt;
    wire [21:0]  pa, da, ma, vh, vl;
    wire [3:0]   we;
    wire [7:0]   wdat;
    wire [5:0]   ssg;
    wire         wt, p21, frm, ins;
    integer      fails = 0, samples_checked = 0, i;

    segx_mmu segx_mmu_i (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt), .PORT_RDATA_IN(prt),
        .PORT_WE_OUT(we), .PORT_WDATA_OUT(wdat), .PORTS_IN_PAGE21_OUT(p21), .FAR_LOAD_IN(fl),
        .FAR_SEG_IN(fs), .FAR_RET_IN(fr), .IRQ_ENTRY_IN(ie), .IRQ_EXIT_IN(ix), .POP_SEG_IN(ps),
        .IRQ_FRAME_CSEG_OUT(frm), .SAVED_SEG_OUT(ssg), .IN_SERVICE_OUT(ins),
        .FETCH_VADDR_IN(fv), .PROG_ADDR_OUT(pa), .DATA_VADDR_IN(dv), .DATA_ADDR_OUT(da),
        .DMA_VADDR_IN(mv), .DMA_ADDR_OUT(ma), .VEC_KIND_IN(vk), .VEC_PTR_IN(vp),
        .VEC_HI_ADDR_OUT(vh), .VEC_LO_ADDR_OUT(vl));
    segx_port_model segx_port_model_i (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
        .PORT_WE_IN(we), .PORT_WDATA_IN(wdat), .PORT_RDATA_OUT(prt));

    // 125 MHz clock
    always #4 CLK_IN = ~CLK_IN;

    task check(input [118:0] seen, input [118:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("wrong value at %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask

    task report_and_stop;
        begin
            $display("checked %0d mismatched %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // avalon access, held until waitrequest is seen low
    task bus(input w, input [5:0] a, input [7:0] d, input [31:0] e);
        begin
            if (!w)
                rq.push_back(e);
            @(posedge CLK_IN);
            adr <= a;
            wd <= {24'h0, d};
            wr <= w;
            rd <= !w;
            @(posedge CLK_IN);
            while (wt !== 1'h0)
                @(posedge CLK_IN);
            rd <= 1'h0;
            wr <= 1'h0;
        end
    endtask

    // vector address expected for a kind
    function [21:0] vx(input [1:0] k, input [7:0] p);
        case (k)
            2'h0: vx = 22'h0;
            2'h1: vx = {is, 16'h0002};
            2'h2: vx = {is, 16'h0004};
            default: vx = {is, 8'h00, p[7:1], 1'h0};
        endcase
    endfunction

    // one cycle of random virtual addresses, expectation noted
    task chk_addr(input [1:0] k);
        reg [15:0] f, d, m;
        reg [7:0]  p;
        reg [5:0]  s;
        begin
            f = $urandom;
            d = $urandom;
            m = $urandom;
            p = $urandom;
            s = (insv && !sv) ? is : cs;
            aq.push_back({s, f, pg[d[15:14]], d[13:0], xsel ? xs : is, m, vx(k, p),
                vx(k, p) + 22'h1, reloc, sv, insv, cs});
            @(posedge CLK_IN);
            fv <= f;
            dv <= d;
            mv <= m;
            vk <= k;
            vp <= p;
            aval <= 1'h1;
            @(posedge CLK_IN);
            aval <= 1'h0;
        end
    endtask

    // core event pulse: {far load, far return, entry, exit}
    task ev(input [3:0] e, input [5:0] s);
        begin
            @(posedge CLK_IN);
            {fl, fr, ie, ix} <= e;
            fs <= s;
            ps <= s;
            @(posedge CLK_IN);
            {fl, fr, ie, ix} <= 4'h0;
        end
    endtask

    // result watcher takes the oldest note
    always @(posedge CLK_IN) begin
        av1 <= aval;
        if (rd && wt === 1'h0)
            check(rdat, rq.pop_front());
        if (av1)
            check({pa, da, ma, vh, vl, p21, frm, ins, ssg}, aq.pop_front());
    end

    initial begin
        #40000;
        fails = fails + 1;
        report_and_stop;
    end

    initial begin
        void'($urandom(14197));
        repeat (5) @(posedge CLK_IN);
        SYS_RST_IN <= 1'h0;
        for (i = 0; i < 16; i = i + 1)
            bus(1'h0, i * 4, 8'h00, (i >= 10 && i <= 13) ? 32'hFF : 32'h0);
        is = $urandom % 32;
        xs = $urandom % 32;
        for (i = 0; i < 4; i = i + 1) begin
            pg[i] = $urandom;
            bus(1'h1, i * 4, pg[i], 32'h0);
        end
        bus(1'h1, 6'h14, is, 32'h0);
        bus(1'h1, 6'h18, xs, 32'h0);
        for (i = 0; i < 4; i = i + 1)
            chk_addr(i);
        xsel = 1'h1;
        bus(1'h1, 6'h20, 8'h01, 32'h0);
        chk_addr(3);
        cs = $urandom % 32;
        ev(4'h8, cs);
        chk_addr(1);
        cs = $urandom % 32;
        ev(4'h4, cs);
        chk_addr(2);
        insv = 1'h1;
        ev(4'h2, 6'h00);
        // code segment written while unused in compat isr
        cs = $urandom % 32;
        bus(1'h1, 6'h10, cs, 32'h0);
        chk_addr(3);
        // nesting depth one, in service
        bus(1'h0, 6'h24, 8'h00, 32'h11);
        ev(4'h1, 6'h00);
        insv = 1'h0;
        chk_addr(0);
        // save mode, code segment never bus written
        sv = 1'h1;
        bus(1'h1, 6'h1C, 8'h40, 32'h0);
        bus(1'h0, 6'h1C, 8'h00, 32'h40);
        old = cs;
        insv = 1'h1;
        ev(4'h2, 6'h00);
        cs = is;
        chk_addr(2);
        bus(1'h0, 6'h10, 8'h00, is);
        cs = old;
        ev(4'h1, old);
        insv = 1'h0;
        chk_addr(1);
        reloc = 1'h1;
        bus(1'h1, 6'h1C, 8'h60, 32'h0);
        chk_addr(0);
        bus(1'h0, 6'h28, 8'h00, pg[0]);
        bus(1'h0, 6'h00, 8'h00, 32'hFF);
        bus(1'h1, 6'h04, 8'hA5, 32'h0);
        bus(1'h0, 6'h04, 8'h00, 32'hA5);
        // low lane off: write refused
        be <= 4'h0;
        bus(1'h1, 6'h14, 8'h3F, 32'h0);
        be <= 4'hF;
        bus(1'h0, 6'h14, 8'h00, is);
        repeat (4) @(posedge CLK_IN);
        report_and_stop;
    end
endmodule // test_segx_mmu

// file: verilog/segx_mmu.v
// segment and page address extension unit with avalon register slave
`timescale 1ns/1ps
`include "segx_defines.vh"

module segx_mmu (
    input  wire        CLK_IN,
    input  wire        SYS_RST_IN,
    // avalon-mm slave
    input  wire [5:0]  AVS_ADDRESS_IN,
    input  wire        AVS_READ_IN,
    input  wire        AVS_WRITE_IN,
    input  wire [31:0] AVS_WRITEDATA_IN,
    input  wire [3:0]  AVS_BYTEENABLE_IN,
    output reg  [31:0] AVS_READDATA_OUT,
    output wire        AVS_WAITREQUEST_OUT,
    // port 0-3 data registers living outside
    input  wire [31:0] PORT_RDATA_IN,
    output reg  [3:0]  PORT_WE_OUT,
    output reg  [7:0]  PORT_WDATA_OUT,
    output wire        PORTS_IN_PAGE21_OUT,
    // core control events
    input  wire        FAR_LOAD_IN,
    input  wire [5:0]  FAR_SEG_IN,
    input  wire        FAR_RET_IN,
    input  wire        IRQ_ENTRY_IN,
    input  wire        IRQ_EXIT_IN,
    input  wire [5:0]  POP_SEG_IN,
    output wire        IRQ_FRAME_CSEG_OUT,
    output wire [5:0]  SAVED_SEG_OUT,
    output wire        IN_SERVICE_OUT,
    // address paths
    input  wire [15:0] FETCH_VADDR_IN,
    output reg  [21:0] PROG_ADDR_OUT,
    input  wire [15:0] DATA_VADDR_IN,
    output reg  [21:0] DATA_ADDR_OUT,
    input  wire [15:0] DMA_VADDR_IN,
    output reg  [21:0] DMA_ADDR_OUT,
    input  wire [1:0]  VEC_KIND_IN,
    input  wire [7:0]  VEC_PTR_IN,
    output reg  [21:0] VEC_HI_ADDR_OUT,
    output reg  [21:0] VEC_LO_ADDR_OUT
);

    // segment over 16-bit virtual address
    function [21:0] seg_extend;
        input [5:0]  seg;
        input [15:0] vaddr;
        begin
            seg_extend = {seg, vaddr};
        end
    endfunction

    // register state
    reg  [7:0]  page_q [0:3];
    reg  [5:0]  code_segment_reg_q;
    reg  [5:0]  interrupt_segment_reg_q;
    reg  [5:0]  transfer_segment_reg_q;
    reg         page_reg_relocate_q;
    reg         save_code_seg_on_irq_q;
    reg         transfer_segment_select_q;
    reg  [3:0]  nest_q;
    reg         ack_q;

    wire        bus_req;
    wire        wr_fire;
    wire        lane0;
    wire [3:0]  word_idx;
    wire        hit_page21;
    wire        hit_grpe;
    wire [1:0]  slot;
    wire        slot_is_page;
    wire [7:0]  port_byte;
    wire [5:0]  fetch_seg;
    wire [5:0]  dma_seg;
    wire [1:0]  page_sel;
    reg  [7:0]  rd_byte;
    reg  [15:0] vec_ofs;
    reg  [5:0]  vec_seg;
    integer     i;

    // bus decode
    assign bus_req    = AVS_READ_IN | AVS_WRITE_IN;
    assign wr_fire    = AVS_WRITE_IN & ack_q;
    assign lane0      = AVS_BYTEENABLE_IN[0];
    assign word_idx   = AVS_ADDRESS_IN[5:2];
    assign hit_page21 = (AVS_ADDRESS_IN <= `SEGX_OFS_PAGE3);
    assign hit_grpe   = (AVS_ADDRESS_IN >= `SEGX_OFS_GRPE0) &&
                        (AVS_ADDRESS_IN <= `SEGX_OFS_GRPE3);
    assign slot       = hit_page21 ? word_idx[1:0] : (word_idx[1:0] + 2'h2);
    // slot swap on relocate
    // page registers answer in group e when relocated, else in page 21
    assign slot_is_page = hit_page21 ? ~page_reg_relocate_q : page_reg_relocate_q;
    assign port_byte  = PORT_RDATA_IN[{slot, 3'b000} +: 8];
    assign PORTS_IN_PAGE21_OUT = page_reg_relocate_q;

    // one wait cycle per access, answer on the second
    assign AVS_WAITREQUEST_OUT = bus_req & ~ack_q;

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // read mux
    always @* begin
        rd_byte = 8'h00;
        if (hit_page21 || hit_grpe) begin
            rd_byte = slot_is_page ? page_q[slot] : port_byte;
        end else begin
            case (AVS_ADDRESS_IN)
                `SEGX_OFS_CODESEG: rd_byte = {2'b00, code_segment_reg_q};
                `SEGX_OFS_IRQSEG:  rd_byte = {2'b00, interrupt_segment_reg_q};
                `SEGX_OFS_XFERSEG: rd_byte = {2'b00, transfer_segment_reg_q};
                `SEGX_OFS_EXTMODE: begin
                    rd_byte = 8'h00;
                    rd_byte[`SEGX_BIT_RELOC]  = page_reg_relocate_q;
                    rd_byte[`SEGX_BIT_SAVECS] = save_code_seg_on_irq_q;
                end
                `SEGX_OFS_XFERPFX: begin
                    rd_byte = 8'h00;
                    rd_byte[`SEGX_BIT_XSEL] = transfer_segment_select_q;
                end
                `SEGX_OFS_STATUS: begin
                    rd_byte = {nest_q, 4'h0};
                    rd_byte[`SEGX_BIT_INSVC] = (nest_q != 4'h0);
                end
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // read data captured in the wait cycle
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            AVS_READDATA_OUT <= 32'h00000000;
        end else if (AVS_READ_IN && !ack_q) begin
            AVS_READDATA_OUT <= {24'h000000, rd_byte};
        end
    end

    // port register writes routed by the swap
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            PORT_WE_OUT    <= 4'h0;
            PORT_WDATA_OUT <= 8'h00;
        end else begin
            PORT_WE_OUT <= 4'h0;
            if (wr_fire && lane0 && (hit_page21 || hit_grpe) && !slot_is_page) begin
                PORT_WE_OUT[slot] <= 1'b1;
                PORT_WDATA_OUT    <= AVS_WRITEDATA_IN[7:0];
            end
        end
    end

    // data page registers
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            for (i = 0; i < 4; i = i + 1) begin
                page_q[i] <= `SEGX_RST_PAGE;
            end
        end else if (wr_fire && lane0 && (hit_page21 || hit_grpe) && slot_is_page) begin
            page_q[slot] <= AVS_WRITEDATA_IN[7:0];
        end
    end

    // mode, segment and transfer prefix registers
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            interrupt_segment_reg_q   <= `SEGX_RST_SEG;
            transfer_segment_reg_q    <= `SEGX_RST_SEG;
            page_reg_relocate_q       <= 1'b0;
            save_code_seg_on_irq_q    <= 1'b0;
            transfer_segment_select_q <= 1'b0;
        end else if (wr_fire && lane0) begin
            case (AVS_ADDRESS_IN)
                `SEGX_OFS_IRQSEG:  interrupt_segment_reg_q <= AVS_WRITEDATA_IN[5:0];
                `SEGX_OFS_XFERSEG: transfer_segment_reg_q  <= AVS_WRITEDATA_IN[5:0];
                `SEGX_OFS_EXTMODE: begin
                    page_reg_relocate_q    <= AVS_WRITEDATA_IN[`SEGX_BIT_RELOC];
                    save_code_seg_on_irq_q <= AVS_WRITEDATA_IN[`SEGX_BIT_SAVECS];
                end
                `SEGX_OFS_XFERPFX: transfer_segment_select_q <= AVS_WRITEDATA_IN[`SEGX_BIT_XSEL];
                default: ;
            endcase
        end
    end

    // code segment: far load, far return and save-mode entry/exit win over a bus write in the same cycle
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            code_segment_reg_q <= `SEGX_RST_SEG;
        end else if (FAR_LOAD_IN) begin
            code_segment_reg_q <= FAR_SEG_IN;
        end else if (FAR_RET_IN) begin
            code_segment_reg_q <= POP_SEG_IN;
        end else if (IRQ_ENTRY_IN && save_code_seg_on_irq_q) begin
            code_segment_reg_q <= interrupt_segment_reg_q;
        end else if (IRQ_EXIT_IN && save_code_seg_on_irq_q) begin
            code_segment_reg_q <= POP_SEG_IN;
        end else if (wr_fire && lane0 && (AVS_ADDRESS_IN == `SEGX_OFS_CODESEG)) begin
            // software write, only safe in compat isr
            code_segment_reg_q <= AVS_WRITEDATA_IN[5:0];
        end
    end

    // interrupt nesting depth, saturating
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            nest_q <= 4'h0;
        end else if (IRQ_ENTRY_IN && !IRQ_EXIT_IN && (nest_q != `SEGX_NEST_MAX)) begin
            nest_q <= nest_q + 4'h1;
        end else if (IRQ_EXIT_IN && !IRQ_ENTRY_IN && (nest_q != 4'h0)) begin
            nest_q <= nest_q - 4'h1;
        end
    end

    assign IN_SERVICE_OUT = (nest_q != 4'h0);

    // frame carries old segment in save mode
    assign IRQ_FRAME_CSEG_OUT = save_code_seg_on_irq_q;
    assign SAVED_SEG_OUT      = code_segment_reg_q;

    // interrupt segment fetches in compat isr
    // far loads there leave fetch unchanged
    assign fetch_seg = (IN_SERVICE_OUT && !save_code_seg_on_irq_q) ?
                       interrupt_segment_reg_q : code_segment_reg_q;

    assign dma_seg  = transfer_segment_select_q ?
                      transfer_segment_reg_q : interrupt_segment_reg_q;

    // top two bits pick the page
    assign page_sel = DATA_VADDR_IN[15:14];

    // registered physical addresses
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            PROG_ADDR_OUT <= 22'h000000;
            DATA_ADDR_OUT <= 22'h000000;
            DMA_ADDR_OUT  <= 22'h000000;
        end else begin
            PROG_ADDR_OUT <= seg_extend(fetch_seg, FETCH_VADDR_IN);
            DATA_ADDR_OUT <= {page_q[page_sel], DATA_VADDR_IN[`SEGX_OFS_W-1:0]};
            DMA_ADDR_OUT  <= seg_extend(dma_seg, DMA_VADDR_IN);
        end
    end

    // vector location select
    always @* begin
        vec_seg = interrupt_segment_reg_q;
        vec_ofs = `SEGX_VEC_RESET;
        case (VEC_KIND_IN)
            `SEGX_VK_RESET: begin
                vec_seg = `SEGX_RST_SEG;
                vec_ofs = `SEGX_VEC_RESET;
            end
            `SEGX_VK_DIVZ: vec_ofs = `SEGX_VEC_DIVZ;
            `SEGX_VK_TOP:  vec_ofs = `SEGX_VEC_TOP;
            `SEGX_VK_TABLE: vec_ofs = {8'h00, VEC_PTR_IN[7:1], 1'b0};
            default: vec_ofs = `SEGX_VEC_RESET;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            VEC_HI_ADDR_OUT <= 22'h000000;
            VEC_LO_ADDR_OUT <= 22'h000001;
        end else begin
            VEC_HI_ADDR_OUT <= seg_extend(vec_seg, vec_ofs);
            VEC_LO_ADDR_OUT <= seg_extend(vec_seg, vec_ofs | 16'h0001);
        end
    end

endmodule // segx_mmu
